// File: hdl/tmr8_pkg.sv
package tmr8_pkg;
	// register byte addresses on the apb bus
	localparam logic [7:0] TMR8_ADDR_CTRL_A   = 8'h00;
	localparam logic [7:0] TMR8_ADDR_CTRL_B   = 8'h04;
	localparam logic [7:0] TMR8_ADDR_COUNT    = 8'h08;
	localparam logic [7:0] TMR8_ADDR_CMP_A    = 8'h0C;
	localparam logic [7:0] TMR8_ADDR_CMP_B    = 8'h10;
	localparam logic [7:0] TMR8_ADDR_STATUS   = 8'h14;
	localparam logic [7:0] TMR8_ADDR_CLEAR    = 8'h18;
	localparam logic [7:0] TMR8_ADDR_IRQ_EN   = 8'h1C;
	localparam logic [7:0] TMR8_ADDR_ACK      = 8'h20;

	// control a fields
	localparam int TMR8_CA_WGM_LO   = 0;
	localparam int TMR8_CA_COMB_LO  = 4;
	localparam int TMR8_CA_COMA_LO  = 6;
	// control b fields
	localparam int TMR8_CB_CS_LO    = 0;
	localparam int TMR8_CB_WGM2     = 3;
	localparam int TMR8_CB_GIE      = 7;
	// status / enable / clear / ack bit positions
	localparam int TMR8_ST_OVF      = 0;
	localparam int TMR8_ST_MA       = 1;
	localparam int TMR8_ST_MB       = 2;

	localparam logic [7:0]  TMR8_RST_BYTE = 8'h00;
	localparam logic [7:0]  TMR8_TOP_MAX  = 8'hFF;
	localparam logic [7:0]  TMR8_TOP_8BIT = 8'hFF;
	localparam logic [9:0]  TMR8_PRE_ZERO = 10'h000;
	localparam logic [31:0] TMR8_RD_ZERO  = 32'h0000_0000;

	// clock select codes
	localparam logic [2:0] TMR8_CS_STOP  = 3'h0;
	localparam logic [2:0] TMR8_CS_DIV1  = 3'h1;
	localparam logic [2:0] TMR8_CS_DIV8  = 3'h2;
	localparam logic [2:0] TMR8_CS_DIV32 = 3'h3;
	localparam logic [2:0] TMR8_CS_DIV64 = 3'h4;
	localparam logic [2:0] TMR8_CS_DIV128 = 3'h5;
	localparam logic [2:0] TMR8_CS_DIV256 = 3'h6;
	localparam logic [2:0] TMR8_CS_DIV1024 = 3'h7;

	// waveform modes
	localparam logic [2:0] TMR8_WGM_NORMAL  = 3'h0;
	localparam logic [2:0] TMR8_WGM_PC_FF   = 3'h1;
	localparam logic [2:0] TMR8_WGM_CTC     = 3'h2;
	localparam logic [2:0] TMR8_WGM_FAST_FF = 3'h3;
	localparam logic [2:0] TMR8_WGM_PC_OCA  = 3'h5;
	localparam logic [2:0] TMR8_WGM_FAST_OCA = 3'h7;

	typedef struct packed {
		logic [7:0]  ctrl_a;
		logic [7:0]  ctrl_b;
		logic [7:0]  count;
		logic [7:0]  cmp_a;
		logic [7:0]  cmp_b;
		logic [7:0]  cmp_a_buf;
		logic [7:0]  cmp_b_buf;
		logic [2:0]  status;
		logic [2:0]  irq_en;
		logic        down;
		logic        block_match;
		logic [9:0]  prescale;
		logic        ext_prev;
		logic        out_a;
		logic        out_b;
		logic        irq;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} tmr8_state_t;
endpackage

// File: hdl/tmr8_timer.sv
// Notes on behaviour
// - counter clears, counts up or down once per timer tick, direction chosen internally
// - clock select: 0 stops, 1 undivided (external pin edges when I_EXT_ENABLE is set), 2..7 divide by 8,32,64,128,256,1024
// - software may read and write the counter at any time
// - a software write to the counter beats a same-cycle count or clear
// - waveform mode is three bits: two in control a, top bit in control b
// - bottom flags zero, top flags mode maximum; generator uses both
// - overflow flag set per mode, cleared by vector acknowledge or writing one
// - overflow interrupt needs global enable, overflow enable and overflow flag
// - comparator checks the counter against both compare registers continuously
// - a match sets its flag on the timer tick after the match
// - enabled set compare flag requests interrupt; cleared by acknowledge or writing one
// - each output derives from match, waveform mode and its compare output mode
// - external pin clocking works even when that pin is an output
// - a counter write suppresses the compare match on the next timer tick
// - a match sets its flag (an interrupt when enabled) and drives the channel output only as waveform and compare output modes allow
`timescale 1ns/10ps
`default_nettype none
module tmr8_timer
	import tmr8_pkg::*;
(
	input  wire logic        I_CLK,
	input  wire logic        I_SYS_RST,
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [7:0]  I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	input  wire logic        I_EXT_COUNT_PIN,
	input  wire logic        I_EXT_FALLING,
	input  wire logic        I_EXT_ENABLE,
	output logic             O_PREADY,
	output logic [31:0]      O_PRDATA,
	output logic             O_PSLVERR,
	output logic             O_COMPARE_OUT_A,
	output logic             O_COMPARE_OUT_B,
	output logic             O_IRQ
);
	tmr8_state_t s_r;
	tmr8_state_t s_nxt;

	logic [2:0] wgm;
	logic [2:0] cs;
	logic       tick;
	logic [7:0] top_val;
	logic       at_top;
	logic       at_bottom;
	logic       pwm_mode;
	logic       pc_mode;
	logic       fast_mode;
	logic       match_a;
	logic       match_b;
	logic       ovf_evt;
	logic       ext_edge;
	logic       wr;
	logic       rd;
	logic [7:0] wb;
	logic       cnt_write;
	logic [1:0] com_a;
	logic [1:0] com_b;
	logic [2:0] set_evt;
	logic       addr_ok;

	assign wgm = {s_r.ctrl_b[TMR8_CB_WGM2], s_r.ctrl_a[TMR8_CA_WGM_LO +: 2]};
	assign cs  = s_r.ctrl_b[TMR8_CB_CS_LO +: 3];
	assign com_a = s_r.ctrl_a[TMR8_CA_COMA_LO +: 2];
	assign com_b = s_r.ctrl_a[TMR8_CA_COMB_LO +: 2];
	assign wr  = I_PSEL && I_PENABLE && I_PWRITE && s_r.pready;
	// read data and the error flag are captured in setup so they stand with ready
	assign rd  = I_PSEL && !I_PENABLE && !I_PWRITE;
	assign addr_ok = I_PADDR inside {TMR8_ADDR_CTRL_A, TMR8_ADDR_CTRL_B, TMR8_ADDR_COUNT,
		TMR8_ADDR_CMP_A, TMR8_ADDR_CMP_B, TMR8_ADDR_STATUS, TMR8_ADDR_CLEAR,
		TMR8_ADDR_IRQ_EN, TMR8_ADDR_ACK};
	assign wb  = I_PWDATA[7:0];
	assign cnt_write = wr && (I_PADDR == TMR8_ADDR_COUNT);

	// external pin sampled regardless of its direction setting
	assign ext_edge = I_EXT_FALLING ? (s_r.ext_prev && !I_EXT_COUNT_PIN)
		: (!s_r.ext_prev && I_EXT_COUNT_PIN);

	always_comb begin
		unique case (cs)
			TMR8_CS_STOP:    tick = 1'b0;
			TMR8_CS_DIV1:    tick = I_EXT_ENABLE ? ext_edge : 1'b1;
			TMR8_CS_DIV8:    tick = (s_r.prescale[2:0] == 3'h7);
			TMR8_CS_DIV32:   tick = (s_r.prescale[4:0] == 5'h1F);
			TMR8_CS_DIV64:   tick = (s_r.prescale[5:0] == 6'h3F);
			TMR8_CS_DIV128:  tick = (s_r.prescale[6:0] == 7'h7F);
			TMR8_CS_DIV256:  tick = (s_r.prescale[7:0] == 8'hFF);
			TMR8_CS_DIV1024: tick = (s_r.prescale == 10'h3FF);
		endcase
	end

	assign fast_mode = (wgm == TMR8_WGM_FAST_FF) || (wgm == TMR8_WGM_FAST_OCA);
	assign pc_mode   = (wgm == TMR8_WGM_PC_FF) || (wgm == TMR8_WGM_PC_OCA);
	assign pwm_mode  = fast_mode || pc_mode;
	assign top_val   = (wgm == TMR8_WGM_CTC || wgm == TMR8_WGM_PC_OCA
		|| wgm == TMR8_WGM_FAST_OCA) ? s_r.cmp_a : TMR8_TOP_8BIT;
	assign at_top    = (s_r.count == top_val);
	assign at_bottom = (s_r.count == TMR8_RST_BYTE);
	assign match_a   = (s_r.count == s_r.cmp_a) && !s_r.block_match;
	assign match_b   = (s_r.count == s_r.cmp_b) && !s_r.block_match;
	// flags that hardware sets in this cycle; a same-cycle clear must not undo them
	assign set_evt   = tick ? {match_b, match_a, ovf_evt} : 3'h0;

	always_comb begin
		unique case (1'b1)
			pc_mode:   ovf_evt = at_bottom;
			fast_mode: ovf_evt = at_top;
			default:   ovf_evt = (s_r.count == TMR8_TOP_MAX);
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.ext_prev = I_EXT_COUNT_PIN;
		s_nxt.prescale = (cs == TMR8_CS_STOP) ? TMR8_PRE_ZERO : s_r.prescale + 10'h001;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;
		if (tick) begin
			s_nxt.block_match = 1'b0;
			// count, clear, or reverse per mode
			if (pc_mode) begin
				if (!s_r.down) begin
					s_nxt.count = at_top ? s_r.count - 8'h01 : s_r.count + 8'h01;
					s_nxt.down = at_top;
				end else begin
					s_nxt.count = at_bottom ? s_r.count + 8'h01 : s_r.count - 8'h01;
					s_nxt.down = !at_bottom;
				end
			end else begin
				s_nxt.down = 1'b0;
				s_nxt.count = at_top ? TMR8_RST_BYTE : s_r.count + 8'h01;
			end
			// pwm compare values update at the extreme
			if ((fast_mode && at_top) || (pc_mode && at_top)) begin
				s_nxt.cmp_a = s_r.cmp_a_buf;
				s_nxt.cmp_b = s_r.cmp_b_buf;
			end
			// flags set on the tick that follows the match
			if (match_a) s_nxt.status[TMR8_ST_MA] = 1'b1;
			if (match_b) s_nxt.status[TMR8_ST_MB] = 1'b1;
			if (ovf_evt) s_nxt.status[TMR8_ST_OVF] = 1'b1;
			// waveform outputs
			if (!pwm_mode) begin
				if (match_a) begin
					unique case (com_a)
						2'h1: s_nxt.out_a = !s_r.out_a;
						2'h2: s_nxt.out_a = 1'b0;
						2'h3: s_nxt.out_a = 1'b1;
						default: s_nxt.out_a = s_r.out_a;
					endcase
				end
				if (match_b) begin
					unique case (com_b)
						2'h1: s_nxt.out_b = !s_r.out_b;
						2'h2: s_nxt.out_b = 1'b0;
						2'h3: s_nxt.out_b = 1'b1;
						default: s_nxt.out_b = s_r.out_b;
					endcase
				end
			end else begin
				if (fast_mode && at_top) begin
					s_nxt.out_a = (com_a == 2'h2) ? 1'b1 : (com_a == 2'h3) ? 1'b0 : s_r.out_a;
					s_nxt.out_b = (com_b == 2'h2) ? 1'b1 : (com_b == 2'h3) ? 1'b0 : s_r.out_b;
				end
				if (match_a && !(fast_mode && at_top)) begin
					if (com_a == 2'h1 && wgm[2]) s_nxt.out_a = !s_r.out_a;
					else if (com_a[1]) s_nxt.out_a = com_a[0] ^ (pc_mode && s_r.down);
				end
				if (match_b && !(fast_mode && at_top) && com_b[1])
					s_nxt.out_b = com_b[0] ^ (pc_mode && s_r.down);
			end
		end
		// register writes
		if (wr) begin
			s_nxt.pready = 1'b0;
			unique case (I_PADDR)
				TMR8_ADDR_CTRL_A: s_nxt.ctrl_a = wb;
				TMR8_ADDR_CTRL_B: s_nxt.ctrl_b = wb;
				TMR8_ADDR_COUNT: begin
					s_nxt.count = wb;
					s_nxt.block_match = 1'b1;
				end
				TMR8_ADDR_CMP_A: begin
					s_nxt.cmp_a_buf = wb;
					if (!pwm_mode) s_nxt.cmp_a = wb;
				end
				TMR8_ADDR_CMP_B: begin
					s_nxt.cmp_b_buf = wb;
					if (!pwm_mode) s_nxt.cmp_b = wb;
				end
				// ones clear, zeros ignored; a same-cycle set above survives
				TMR8_ADDR_CLEAR: s_nxt.status = s_nxt.status
					& ~(wb[2:0] & ~set_evt);
				TMR8_ADDR_IRQ_EN: s_nxt.irq_en = wb[2:0];
				TMR8_ADDR_ACK: s_nxt.status = s_nxt.status
					& ~(wb[2:0] & ~set_evt);
				default: ;
			endcase
		end
		if (I_PSEL && !I_PENABLE) begin
			s_nxt.pready  = 1'b1;
			s_nxt.pslverr = !addr_ok;
		end
		if (rd) begin
			s_nxt.prdata = TMR8_RD_ZERO;
			unique case (I_PADDR)
				TMR8_ADDR_CTRL_A: s_nxt.prdata[7:0] = s_r.ctrl_a;
				TMR8_ADDR_CTRL_B: s_nxt.prdata[7:0] = s_r.ctrl_b;
				TMR8_ADDR_COUNT:  s_nxt.prdata[7:0] = s_r.count;
				TMR8_ADDR_CMP_A:  s_nxt.prdata[7:0] = s_r.cmp_a_buf;
				TMR8_ADDR_CMP_B:  s_nxt.prdata[7:0] = s_r.cmp_b_buf;
				TMR8_ADDR_STATUS: s_nxt.prdata[2:0] = s_r.status;
				TMR8_ADDR_IRQ_EN: s_nxt.prdata[2:0] = s_r.irq_en;
				TMR8_ADDR_CLEAR, TMR8_ADDR_ACK: s_nxt.prdata = TMR8_RD_ZERO;
				default: s_nxt.prdata = TMR8_RD_ZERO;
			endcase
		end
		s_nxt.irq = s_r.ctrl_b[TMR8_CB_GIE] && |(s_nxt.status & s_nxt.irq_en);
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign O_PREADY        = s_r.pready;
	assign O_PRDATA        = s_r.prdata;
	assign O_PSLVERR       = s_r.pslverr;
	assign O_COMPARE_OUT_A = s_r.out_a;
	assign O_COMPARE_OUT_B = s_r.out_b;
	assign O_IRQ           = s_r.irq;
endmodule
`default_nettype wire

// File: bench/tmr8_chk.sv
`timescale 1ns/10ps
`default_nettype none
module tmr8_chk import tmr8_pkg::*; (
	input wire logic        I_CLK,
	input wire logic        I_SYS_RST,
	input wire logic        I_PSEL,
	input wire logic        I_PENABLE,
	input wire logic        I_PWRITE,
	input wire logic [7:0]  I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic        O_PREADY,
	input wire logic [31:0] O_PRDATA,
	input wire logic        O_COMPARE_OUT_A,
	input wire logic        O_IRQ
);
	logic       gie_r;
	logic [2:0] en_r;
	logic [2:0] cs_r;
	// shadow of the enables, taken at the same edge as the design
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			gie_r <= 1'b0;
			en_r <= 3'h0;
			cs_r <= 3'h0;
		end else if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE) begin
			if (I_PADDR == TMR8_ADDR_CTRL_B) begin
				gie_r <= I_PWDATA[TMR8_CB_GIE];
				cs_r <= I_PWDATA[2:0];
			end
			if (I_PADDR == TMR8_ADDR_IRQ_EN) begin
				en_r <= I_PWDATA[2:0];
			end
		end
	end
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);
	sequence s_setup;
		I_PSEL && !I_PENABLE;
	endsequence
	a_ready_setup: assert property (s_setup |=> O_PREADY)
		else $error("no ready after setup");
	a_ready_single: assert property (O_PREADY |=> !O_PREADY)
		else $error("ready held");
	a_ready_idle: assert property (!I_PSEL |=> !O_PREADY)
		else $error("ready while idle");
	a_rdata_hold: assert property (!(s_setup && !I_PWRITE) |=> $stable(O_PRDATA))
		else $error("read data moved");
	a_rdata_upper: assert property (O_PRDATA[31:8] == 24'h0)
		else $error("upper read bits set");
	a_irq_gie: assert property (!gie_r [*3] |-> !O_IRQ)
		else $error("irq without global enable");
	a_irq_en: assert property ((en_r == 3'h0) [*3] |-> !O_IRQ)
		else $error("irq without source enable");
	a_stop_quiet: assert property ((cs_r == 3'h0) [*4] |-> $stable(O_COMPARE_OUT_A))
		else $error("output moved while stopped");
endmodule
bind tmr8_timer tmr8_chk u_tmr8_chk (.I_CLK, .I_SYS_RST, .I_PSEL, .I_PENABLE, .I_PWRITE,
	.I_PADDR, .I_PWDATA, .O_PREADY, .O_PRDATA, .O_COMPARE_OUT_A, .O_IRQ);
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench import tmr8_pkg::*;;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic r;} tmr8_row_t;
	logic        clk, rst, psel, pen, pwr, pin, fall, exten, rdy, err, oa, ob, irq;
	logic [7:0]  addr;
	logic [31:0] wdata, prd;
	int          errors, samples_checked, cyc, t0;
	int          divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
	tmr8_row_t   rows[7];
	tmr8_timer u_tmr8_timer (.I_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(addr), .I_PWDATA(wdata), .I_EXT_COUNT_PIN(pin),
		.I_EXT_FALLING(fall), .I_EXT_ENABLE(exten), .O_PREADY(rdy), .O_PRDATA(prd),
		.O_PSLVERR(err), .O_COMPARE_OUT_A(oa), .O_COMPARE_OUT_B(ob), .O_IRQ(irq));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 70000) begin
			errors++;
			report_and_stop();
		end
	end
	task report_and_stop;
		$display("checks=%0d errors=%0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task check(input logic [31:0] g, input logic [31:0] x);
		samples_checked++;
		if (g !== x) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	// error flag and read data are taken at the edge where ready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		e = err;
		q = prd;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task cr(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		check(q, x);
	endtask
	task ws(input logic [7:0] a, input logic [31:0] d, input logic v);
		wr(a, d);
		repeat (3) @(posedge clk);
		check({31'h0, irq}, {31'h0, v});
	endtask
	task irq_wait(input logic v, input int lim);
		for (int n = 0; n < lim && irq !== v; n++) @(posedge clk);
	endtask
	initial begin
		logic [31:0] q;
		logic        e;
		{rst, psel, pen, pwr, pin, fall, exten} = 7'h41;
		addr = 8'h0;
		wdata = 32'h0;
		rows = '{'{TMR8_ADDR_CMP_A, 32'hA5, 32'hA5, 1'b0}, '{TMR8_ADDR_CMP_B, 32'h5A, 32'h5A, 1'b0},
			'{TMR8_ADDR_COUNT, 32'h3C, 32'h3C, 1'b0}, '{TMR8_ADDR_CTRL_A, 32'h52, 32'h52, 1'b0},
			'{TMR8_ADDR_CTRL_B, 32'h80, 32'h80, 1'b0}, '{TMR8_ADDR_STATUS, 32'hFF, 32'h0, 1'b0},
			'{8'h24, 32'hFF, 32'h0, 1'b1}};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d, q, e);
			check({31'h0, e}, {31'h0, rows[i].r});
			if (!rows[i].r) cr(rows[i].a, rows[i].x);
		end
		cr(TMR8_ADDR_COUNT, 32'h3C);
		$display("registers done");
		exten <= 1'b1;
		wr(TMR8_ADDR_COUNT, 32'h0);
		wr(TMR8_ADDR_CTRL_B, 32'h1);
		repeat (10) @(posedge clk) pin <= ~pin;
		repeat (4) @(posedge clk);
		wr(TMR8_ADDR_CTRL_B, 32'h0);
		cr(TMR8_ADDR_COUNT, 32'h5);
		exten <= 1'b0;
		$display("pin clock done");
		wr(TMR8_ADDR_CMP_A, 32'hF);
		wr(TMR8_ADDR_CTRL_A, 32'h2);
		wr(TMR8_ADDR_IRQ_EN, 32'h2);
		for (int c = 1; c < 8; c++) begin
			wr(TMR8_ADDR_CTRL_B, 32'h80);
			wr(TMR8_ADDR_COUNT, 32'h0);
			wr(TMR8_ADDR_CLEAR, 32'h7);
			wr(TMR8_ADDR_CTRL_B, 32'h80 | 32'(c));
			irq_wait(1'b1, 40000);
			t0 = cyc;
			wr(TMR8_ADDR_CLEAR, 32'h2);
			irq_wait(1'b0, 8);
			irq_wait(1'b1, 40000);
			check(32'(cyc - t0), 32'(16 * divs[c]));
		end
		$display("prescaler done");
		wr(TMR8_ADDR_CTRL_B, 32'h80);
		wr(TMR8_ADDR_CTRL_A, 32'h0);
		wr(TMR8_ADDR_COUNT, 32'hF0);
		wr(TMR8_ADDR_IRQ_EN, 32'h1);
		wr(TMR8_ADDR_CLEAR, 32'h7);
		ws(TMR8_ADDR_CTRL_B, 32'h81, 1'b0);
		irq_wait(1'b1, 300);
		ws(TMR8_ADDR_CTRL_B, 32'h80, 1'b1);
		cr(TMR8_ADDR_STATUS, 32'h1);
		ws(TMR8_ADDR_CTRL_B, 32'h0, 1'b0);
		ws(TMR8_ADDR_CTRL_B, 32'h80, 1'b1);
		ws(TMR8_ADDR_IRQ_EN, 32'h0, 1'b0);
		ws(TMR8_ADDR_IRQ_EN, 32'h1, 1'b1);
		ws(TMR8_ADDR_CLEAR, 32'h0, 1'b1);
		ws(TMR8_ADDR_ACK, 32'h1, 1'b0);
		cr(TMR8_ADDR_STATUS, 32'h0);
		$display("overflow done");
		wr(TMR8_ADDR_CTRL_B, 32'h81);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		cr(TMR8_ADDR_COUNT, 32'h0);
		cr(TMR8_ADDR_CTRL_B, 32'h0);
		$display("reset done");
		// toggle on channel a, set on channel b, normal counting
		wr(TMR8_ADDR_CMP_A, 32'h10);
		wr(TMR8_ADDR_CMP_B, 32'h20);
		wr(TMR8_ADDR_CTRL_A, 32'h70);
		wr(TMR8_ADDR_COUNT, 32'h0);
		check({30'h0, ob, oa}, 32'h0);
		wr(TMR8_ADDR_CTRL_B, 32'h1);
		repeat (40) @(posedge clk);
		wr(TMR8_ADDR_COUNT, 32'h80);
		wr(TMR8_ADDR_CTRL_B, 32'h0);
		cr(TMR8_ADDR_COUNT, 32'h84);
		cr(TMR8_ADDR_STATUS, 32'h6);
		check({30'h0, ob, oa}, 32'h3);
		wr(TMR8_ADDR_CLEAR, 32'h7);
		wr(TMR8_ADDR_COUNT, 32'h10);
		wr(TMR8_ADDR_CTRL_B, 32'h1);
		repeat (10) @(posedge clk);
		wr(TMR8_ADDR_CTRL_B, 32'h0);
		cr(TMR8_ADDR_STATUS, 32'h0);
		check({30'h0, ob, oa}, 32'h3);
		$display("compare output done");
		report_and_stop();
	end
endmodule
`default_nettype wire
